/* File: core/pin_sync.sv */
/*
 * Two-flop synchroniser for a group of pin levels.
 * Assumes pins are asynchronous levels; freezes while ce is low.
 */
`timescale 1ns/1ps

module pin_sync #(
	parameter int WIDTH = 1
) (
	// Clock and control
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic ce,
	// Data
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);

	logic [WIDTH-1:0] meta;
	logic [WIDTH-1:0] next_meta;
	logic [WIDTH-1:0] next_q;

	always_comb begin
		next_meta = ce ? d : meta;
		next_q = ce ? meta : q;
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= next_meta;
			q <= next_q;
		end
	end

endmodule : pin_sync

/* File: core/stop_group_status_command.sv */
/*
 * Stop-group status and command register bank of a conveyor module.
 * Assumes a protocol engine that presents register reads and writes from
 * any fieldbus on one shared port, and pulses poll_seen on each assembly poll.
 */
//
// Operation
// - Bit 5 set while a hardwired stop button in the group is pressed.
// - Bit 6 set when stop is due to lost Ethernet; zero when fine.
// - Bit 7 set when stop is due to lost controller connection.
// - Bit 8 set while local left-port stop button is pressed.
// - Bit 9 set while local right-port stop button is pressed.
// - Bit 10 set while the controller commands a stop.
// - Status word zero means no stop is active in the group.
// - Status bits are independent flags, same meaning for every protocol.
// - Command 1 stops the whole group and sets bit 10.
// - Command 2 issues a group start at the proper step.
// - All protocols reach one shared set of 16-bit registers.
// - Access accepted over Modbus TCP, Profinet I/O and EtherNet/IP.
// - Status is read-side, command write-side; both 16 bits wide.
// - Assembly polling silent over 100 ms after a first poll raises a stop.
`timescale 1ns/1ps
`include "stop_group_cfg.svh"

module stop_group_status_command #(
	parameter int unsigned POLL_SILENT_CYCLES =
		32'((`POLL_SILENT_MS * `CLK_HZ) / `MS_PER_S)
) (
	// Clock and control
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic ce,
	// Shared register port
	input wire stop_group_pkg::proto_e acc_proto,
	input wire logic acc_idx,
	input wire logic acc_wr,
	input wire logic acc_rd,
	input wire stop_group_pkg::word_t acc_wdata,
	output stop_group_pkg::word_t acc_rdata,
	output logic acc_ack,
	output logic acc_err,
	// Stop sources
	input wire logic hw_stop_pin,
	input wire logic left_stop_pin,
	input wire logic right_stop_pin,
	input wire logic eth_link_ok_pin,
	input wire logic eip_conn_lost,
	input wire logic pnio_conn_lost,
	input wire logic poll_seen,
	// Group control
	output logic group_stop,
	output logic group_start
);
	import stop_group_pkg::*;

	// ============================================================
	// Pin synchronisation
	logic [3:0] pins_s;
	logic hw_stop_s;
	logic left_s;
	logic right_s;
	logic eth_ok_s;

	pin_sync #(.WIDTH(4)) u_pin_sync (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.ce(ce),
		.d({hw_stop_pin, left_stop_pin, right_stop_pin, eth_link_ok_pin}),
		.q(pins_s)
	);

	assign hw_stop_s = pins_s[3];
	assign left_s = pins_s[2];
	assign right_s = pins_s[1];
	assign eth_ok_s = pins_s[0];

	// ============================================================
	// Register port
	word_t command;
	word_t status;
	word_t next_command;
	word_t next_rdata;
	logic next_ack;
	logic next_err;
	logic acc_ok;
	logic cmd_valid;

	always_comb begin
		acc_ok = (acc_proto != PROTO_NONE) && (acc_wr || acc_rd);
		cmd_valid = (acc_wdata == `CMD_IDLE) || (acc_wdata == `CMD_STOP) ||
			(acc_wdata == `CMD_START);
		next_command = command;
		next_rdata = `STATUS_RST;
		next_ack = 1'b0;
		next_err = 1'b0;
		if (ce && acc_ok) begin
			next_ack = 1'b1;
			if (acc_wr) begin
				// Status is read-only; only known command values are kept
				if (acc_idx == `COMMAND_REG_IDX && cmd_valid) begin
					next_command = acc_wdata;
				end else begin
					next_err = 1'b1;
				end
			end else if (acc_idx == `STATUS_REG_IDX) begin
				next_rdata = status;
			end else begin
				next_err = 1'b1;
			end
		end else if (!ce) begin
			next_rdata = acc_rdata;
			next_ack = acc_ack;
			next_err = acc_err;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			command <= `COMMAND_RST;
			acc_rdata <= `STATUS_RST;
			acc_ack <= 1'b0;
			acc_err <= 1'b0;
		end else begin
			command <= next_command;
			acc_rdata <= next_rdata;
			acc_ack <= next_ack;
			acc_err <= next_err;
		end
	end

	// ============================================================
	// Poll silence watchdog
	logic [31:0] silent_cnt;
	logic poll_armed;
	logic poll_lost;
	logic [31:0] next_silent_cnt;
	logic next_poll_armed;
	logic next_poll_lost;

	always_comb begin
		next_silent_cnt = silent_cnt;
		next_poll_armed = poll_armed;
		next_poll_lost = poll_lost;
		if (ce) begin
			if (poll_seen) begin
				next_silent_cnt = 32'h0000_0000;
				next_poll_armed = 1'b1;
				next_poll_lost = 1'b0;
			end else if (poll_armed && !poll_lost) begin
				if (silent_cnt >= POLL_SILENT_CYCLES) begin
					next_poll_lost = 1'b1;
				end else begin
					next_silent_cnt = silent_cnt + 32'h0000_0001;
				end
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			silent_cnt <= 32'h0000_0000;
			poll_armed <= 1'b0;
			poll_lost <= 1'b0;
		end else begin
			silent_cnt <= next_silent_cnt;
			poll_armed <= next_poll_armed;
			poll_lost <= next_poll_lost;
		end
	end

	// ============================================================
	// Stop status word
	word_t next_status;

	always_comb begin
		next_status = `STATUS_RST;
		next_status[`ST_HW_BUTTON_BIT] = hw_stop_s;
		next_status[`ST_ETH_LOST_BIT] = !eth_ok_s;
		next_status[`ST_CTRL_LOST_BIT] = poll_lost || eip_conn_lost || pnio_conn_lost;
		next_status[`ST_LEFT_BTN_BIT] = left_s;
		next_status[`ST_RIGHT_BTN_BIT] = right_s;
		next_status[`ST_CTRL_STOP_BIT] = (command == `CMD_STOP);
		if (!ce) begin
			next_status = status;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			status <= `STATUS_RST;
		end else begin
			status <= next_status;
		end
	end

	// ============================================================
	// Group stop and start handshake
	start_state_e start_state;
	start_state_e next_start_state;
	logic next_group_stop;
	logic next_group_start;

	always_comb begin
		next_start_state = start_state;
		next_group_stop = group_stop;
		next_group_start = group_start;
		if (ce) begin
			next_group_stop = (status != `STATUS_RST);
			next_group_start = 1'b0;
			unique case (start_state)
				START_IDLE: begin
					// Start only acts on a clean group
					if (command == `CMD_START && status == `STATUS_RST) begin
						next_start_state = START_FIRE;
						next_group_start = 1'b1;
					end
				end
				START_FIRE: begin
					next_start_state = START_HOLD;
				end
				START_HOLD: begin
					// Re-arm only after the start value is withdrawn
					if (command != `CMD_START) begin
						next_start_state = START_IDLE;
					end
				end
				default: begin
					next_start_state = START_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			start_state <= START_IDLE;
			group_stop <= 1'b0;
			group_start <= 1'b0;
		end else begin
			start_state <= next_start_state;
			group_stop <= next_group_stop;
			group_start <= next_group_start;
		end
	end

	// ============================================================
	// Assertions
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	property p_reserved_zero;
		(status & ~`ST_USED_MASK) == `STATUS_RST;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero)
		else $error("reserved status bit set");

	property p_ctrl_stop_bit;
		ce && (command == `CMD_STOP) |=> status[`ST_CTRL_STOP_BIT];
	endproperty
	a_ctrl_stop_bit: assert property (p_ctrl_stop_bit)
		else $error("controller stop not shown in bit 10");

	property p_write_stop;
		ce && acc_wr && acc_proto != PROTO_NONE && acc_idx == `COMMAND_REG_IDX &&
			acc_wdata == `CMD_STOP ##1 ce[*2] |-> status[`ST_CTRL_STOP_BIT] ##1 group_stop;
	endproperty
	a_write_stop: assert property (p_write_stop)
		else $error("stop command did not stop the group");

	property p_bad_cmd_ignored;
		ce && acc_wr && acc_proto != PROTO_NONE && acc_idx == `COMMAND_REG_IDX && !cmd_valid |=>
			command == $past(command) && acc_err;
	endproperty
	a_bad_cmd_ignored: assert property (p_bad_cmd_ignored)
		else $error("unknown command value acted upon");

	property p_no_proto_ignored;
		ce && acc_proto == PROTO_NONE |=> !acc_ack && command == $past(command);
	endproperty
	a_no_proto_ignored: assert property (p_no_proto_ignored)
		else $error("access without protocol accepted");

	property p_stop_follows_status;
		ce |=> group_stop == ($past(status) != `STATUS_RST);
	endproperty
	a_stop_follows_status: assert property (p_stop_follows_status)
		else $error("group stop disagrees with status word");

	property p_start_clean;
		$rose(group_start) |-> $past(status) == `STATUS_RST && $past(command) == `CMD_START
			##1 (!group_start || !$past(ce));
	endproperty
	a_start_clean: assert property (p_start_clean)
		else $error("start issued with stop active or held too long");

	property p_eth_bit;
		ce |=> status[`ST_ETH_LOST_BIT] == !$past(eth_ok_s);
	endproperty
	a_eth_bit: assert property (p_eth_bit)
		else $error("ethernet loss bit wrong");

	property p_poll_timeout;
		ce && poll_armed && !poll_lost && !poll_seen &&
			silent_cnt >= POLL_SILENT_CYCLES |=>
			poll_lost ##1 (status[`ST_CTRL_LOST_BIT] || !$past(ce));
	endproperty
	a_poll_timeout: assert property (p_poll_timeout)
		else $error("poll silence did not raise a stop");

	property p_status_read;
		ce && acc_rd && !acc_wr && acc_proto != PROTO_NONE &&
			acc_idx == `STATUS_REG_IDX |=> acc_ack && acc_rdata == $past(status);
	endproperty
	a_status_read: assert property (p_status_read)
		else $error("status read returned wrong word");

	c_start: cover property (group_start);
	c_poll_lost: cover property (poll_lost);
	c_hw_stop: cover property (status[`ST_HW_BUTTON_BIT] ##1 group_stop);
	c_stop_then_start: cover property (status[`ST_CTRL_STOP_BIT] ##[1:20] group_start);

endmodule : stop_group_status_command

/* File: pkg/stop_group_cfg.svh */
/*
 * Offsets, field positions, reset values and timing counts of the stop-group
 * register bank. Assumes inclusion by bare name from the design files.
 */
`ifndef STOP_GROUP_CFG_SVH
`define STOP_GROUP_CFG_SVH

// ============================================================
// Register indices on the shared internal register port
`define STATUS_REG_IDX 1'b0
`define COMMAND_REG_IDX 1'b1

// ============================================================
// Stop-status bit positions
`define ST_HW_BUTTON_BIT 5
`define ST_ETH_LOST_BIT 6
`define ST_CTRL_LOST_BIT 7
`define ST_LEFT_BTN_BIT 8
`define ST_RIGHT_BTN_BIT 9
`define ST_CTRL_STOP_BIT 10
`define ST_USED_MASK 16'h07E0

// ============================================================
// Command values and reset values
`define CMD_IDLE 16'h0000
`define CMD_STOP 16'h0001
`define CMD_START 16'h0002
`define STATUS_RST 16'h0000
`define COMMAND_RST 16'h0000

// ============================================================
// Timing
`define CLK_HZ 64'd25_000_000
`define POLL_SILENT_MS 64'd100
`define MS_PER_S 64'd1000

`endif

/* File: pkg/stop_group_pkg.sv */
/*
 * Types of the stop-group register bank: protocol codes, start handshake
 * states and the register word. Assumes no surroundings.
 */
package stop_group_pkg;

	// ============================================================
	// Types
	typedef logic [15:0] word_t;

	typedef enum logic [1:0] {
		PROTO_MODBUS = 2'b00,
		PROTO_EIP = 2'b01,
		PROTO_PNIO = 2'b10,
		PROTO_NONE = 2'b11
	} proto_e;

	typedef enum logic [1:0] {
		START_IDLE = 2'b00,
		START_FIRE = 2'b01,
		START_HOLD = 2'b11
	} start_state_e;

endpackage : stop_group_pkg

/* File: sim/plc_model.sv */
/*
 * Remote controller model: single-word reads and writes on the shared port.
 * Assumes the bench clock, one-cycle request pulses and an answer on the next edge.
 */
`timescale 1ns/1ps

module plc_model (
	// Clock
	input wire logic clk_sys,
	// Register port
	output stop_group_pkg::proto_e acc_proto,
	output logic acc_idx,
	output logic acc_wr,
	output logic acc_rd,
	output stop_group_pkg::word_t acc_wdata,
	input wire stop_group_pkg::word_t acc_rdata,
	input wire logic acc_ack,
	input wire logic acc_err
);
	import stop_group_pkg::*;

	initial begin
		acc_proto = PROTO_MODBUS;
		acc_idx = 1'b0;
		acc_wr = 1'b0;
		acc_rd = 1'b0;
		acc_wdata = 16'h0000;
	end

	// One-cycle request pulse, answer taken one edge after the edge where it is registered
	task automatic xfer(input proto_e p, input logic idx, input logic wr,
		input word_t wd, output word_t rd, output logic ack, output logic err);
		@(posedge clk_sys);
		acc_proto <= p;
		acc_idx <= idx;
		acc_wr <= wr;
		acc_rd <= !wr;
		acc_wdata <= wd;
		@(posedge clk_sys);
		acc_wr <= 1'b0;
		acc_rd <= 1'b0;
		// Released data must not keep its last value
		acc_wdata <= ~wd;
		@(posedge clk_sys);
		rd = acc_rdata;
		ack = acc_ack;
		err = acc_err;
	endtask : xfer
endmodule : plc_model

/* File: sim/stop_group_status_command_bench.sv */
/*
 * Self-checking bench of the stop-group register bank, random pin levels.
 * Assumes the controller model and a shortened poll watchdog.
 */
`timescale 1ns/1ps

module stop_group_status_command_bench;
	import stop_group_pkg::*;

	localparam int unsigned SILENT = 20;
	logic clk_sys, rst_n, ce, hw, left, right, eth_ok, eip_lost, pn_lost, poll;
	logic acc_idx, acc_wr, acc_rd, acc_ack, acc_err, group_stop, group_start;
	logic ack, err;
	proto_e acc_proto;
	word_t acc_wdata, acc_rdata, rd, exp_word;
	int num_errors = 0;
	int cmp_count = 0;
	int seen;

	plc_model i_plc (.clk_sys(clk_sys), .acc_proto(acc_proto), .acc_idx(acc_idx),
		.acc_wr(acc_wr), .acc_rd(acc_rd), .acc_wdata(acc_wdata),
		.acc_rdata(acc_rdata), .acc_ack(acc_ack), .acc_err(acc_err));

	stop_group_status_command #(.POLL_SILENT_CYCLES(SILENT)) i_dut (.clk_sys(clk_sys),
		.rst_n(rst_n), .ce(ce), .acc_proto(acc_proto), .acc_idx(acc_idx),
		.acc_wr(acc_wr), .acc_rd(acc_rd), .acc_wdata(acc_wdata),
		.acc_rdata(acc_rdata), .acc_ack(acc_ack), .acc_err(acc_err),
		.hw_stop_pin(hw), .left_stop_pin(left), .right_stop_pin(right),
		.eth_link_ok_pin(eth_ok), .eip_conn_lost(eip_lost), .pnio_conn_lost(pn_lost),
		.poll_seen(poll), .group_stop(group_stop), .group_start(group_start));

	// ============================================================
	// Checking helpers
	task automatic end_of_test;
		if (num_errors == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : end_of_test

	task automatic chk(input word_t got, input word_t exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	function automatic word_t exp_st(input logic h, e, l, r, c, s);
		return {5'h00, s, r, l, c, !e, h, 5'h00};
	endfunction : exp_st

	task automatic acc(input proto_e p, input logic idx, input logic wr, input word_t wd,
		input word_t exp, input logic exp_ack, input logic exp_err);
		i_plc.xfer(p, idx, wr, wd, rd, ack, err);
		chk(rd, exp);
		chk({14'h0000, ack, err}, {14'h0000, exp_ack, exp_err});
	endtask : acc

	task automatic count_start(input int n, input int exp);
		seen = 0;
		repeat (n) begin
			@(posedge clk_sys);
			if (group_start === 1'b1) seen++;
		end
		chk(16'(seen), 16'(exp));
	endtask : count_start

	// ============================================================
	// Clock, watchdog and sequence
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	initial begin
		repeat (5000) @(posedge clk_sys);
		num_errors++;
		end_of_test();
	end

	initial begin
		rst_n = 1'b0;
		ce = 1'b1;
		{hw, eth_ok, left, right, eip_lost, pn_lost, poll} = 7'h20;
		seen = $urandom(3840);
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
		acc(PROTO_MODBUS, 1'b0, 1'b0, 16'h0000, 16'h0000, 1'b1, 1'b0);
		for (int i = 0; i < 24; i++) begin
			@(posedge clk_sys);
			{hw, eth_ok, left, right, eip_lost, pn_lost} <= 6'($urandom());
			repeat (4) @(posedge clk_sys);
			exp_word = exp_st(hw, eth_ok, left, right, eip_lost | pn_lost, 1'b0);
			acc(proto_e'(2'(i % 3)), 1'b0, 1'b0, 16'h0000, exp_word, 1'b1, 1'b0);
			chk({15'h0000, group_stop},
				{15'h0000, eip_lost | pn_lost | hw | left | right | !eth_ok});
		end
		{hw, eth_ok, left, right, eip_lost, pn_lost} <= 6'h10;
		repeat (4) @(posedge clk_sys);
		acc(PROTO_EIP, 1'b1, 1'b1, 16'h0001, 16'h0000, 1'b1, 1'b0);
		repeat (2) @(posedge clk_sys);
		acc(PROTO_PNIO, 1'b0, 1'b0, 16'h0000, 16'h0400, 1'b1, 1'b0);
		chk({15'h0000, group_stop}, 16'h0001);
		acc(PROTO_MODBUS, 1'b1, 1'b1, 16'($urandom_range(65535, 3)), 16'h0000, 1'b1, 1'b1);
		acc(PROTO_MODBUS, 1'b0, 1'b1, 16'hFFFF, 16'h0000, 1'b1, 1'b1);
		acc(PROTO_EIP, 1'b1, 1'b0, 16'h0000, 16'h0000, 1'b1, 1'b1);
		acc(PROTO_NONE, 1'b1, 1'b1, 16'h0000, 16'h0000, 1'b0, 1'b0);
		repeat (2) @(posedge clk_sys);
		acc(PROTO_MODBUS, 1'b0, 1'b0, 16'h0000, 16'h0400, 1'b1, 1'b0);
		// Start held off by a local button, fires once it clears
		left <= 1'b1;
		repeat (4) @(posedge clk_sys);
		acc(PROTO_EIP, 1'b1, 1'b1, 16'h0000, 16'h0000, 1'b1, 1'b0);
		acc(PROTO_EIP, 1'b1, 1'b1, 16'h0002, 16'h0000, 1'b1, 1'b0);
		count_start(6, 0);
		left <= 1'b0;
		count_start(8, 1);
		acc(PROTO_EIP, 1'b1, 1'b1, 16'h0000, 16'h0000, 1'b1, 1'b0);
		// Regular start handshake
		acc(PROTO_PNIO, 1'b1, 1'b1, 16'h0000, 16'h0000, 1'b1, 1'b0);
		acc(PROTO_PNIO, 1'b0, 1'b0, 16'h0000, 16'h0000, 1'b1, 1'b0);
		acc(PROTO_PNIO, 1'b1, 1'b1, 16'h0002, 16'h0000, 1'b1, 1'b0);
		count_start(8, 1);
		acc(PROTO_PNIO, 1'b1, 1'b1, 16'h0000, 16'h0000, 1'b1, 1'b0);
		// Clock enable low: requests ignored, pins and outputs frozen
		ce <= 1'b0;
		hw <= 1'b1;
		repeat (6) @(posedge clk_sys);
		acc(PROTO_MODBUS, 1'b0, 1'b0, 16'h0000, 16'h0000, 1'b0, 1'b0);
		chk({15'h0000, group_stop}, 16'h0000);
		ce <= 1'b1;
		repeat (4) @(posedge clk_sys);
		acc(PROTO_MODBUS, 1'b0, 1'b0, 16'h0000, 16'h0020, 1'b1, 1'b0);
		chk({15'h0000, group_stop}, 16'h0001);
		hw <= 1'b0;
		repeat (4) @(posedge clk_sys);
		// Poll watchdog
		poll <= 1'b1;
		@(posedge clk_sys);
		poll <= 1'b0;
		repeat (SILENT + 4) @(posedge clk_sys);
		acc(PROTO_EIP, 1'b0, 1'b0, 16'h0000, 16'h0080, 1'b1, 1'b0);
		chk({15'h0000, group_stop}, 16'h0001);
		poll <= 1'b1;
		@(posedge clk_sys);
		poll <= 1'b0;
		repeat (3) @(posedge clk_sys);
		acc(PROTO_EIP, 1'b0, 1'b0, 16'h0000, 16'h0000, 1'b1, 1'b0);
		chk({15'h0000, group_stop}, 16'h0000);
		end_of_test();
	end
endmodule : stop_group_status_command_bench
